// ---- src/acis_defs.svh ----
// Purpose: register offsets, field positions and reset values of the interrupt status block
// Assumes: 8-bit register space behind the two-wire slave
// Notes:   definitions only
`ifndef ACIS_DEFS_SVH
`define ACIS_DEFS_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define ACIS_ADDR_STATUS  8'h00
`define ACIS_ADDR_X_MSB   8'h01
`define ACIS_ADDR_Y_MSB   8'h03
`define ACIS_ADDR_Z_MSB   8'h05
`define ACIS_ADDR_SYSMODE 8'h0b
`define ACIS_ADDR_INTSRC  8'h0c
`define ACIS_ADDR_IDENT   8'h0d
`define ACIS_ADDR_FORMAT  8'h0e
`define ACIS_ADDR_CUTOFF  8'h0f
`define ACIS_ADDR_ORIENT  8'h10
`define ACIS_ADDR_FALLMO  8'h16
`define ACIS_ADDR_TRANS   8'h1e
`define ACIS_ADDR_TAP     8'h22
// ----------------------------------------
// field positions and masks
// ----------------------------------------
`define ACIS_BIT_SLEEP    7
`define ACIS_BIT_TRANS    5
`define ACIS_BIT_ORIENT   4
`define ACIS_BIT_TAP      3
`define ACIS_BIT_FALLMO   2
`define ACIS_BIT_SAMPLE   0
`define ACIS_INTSRC_USED  8'hbd
`define ACIS_MASK_FORMAT  8'h13
`define ACIS_MASK_CUTOFF  8'h33
`define ACIS_RST_FORMAT   8'h00
`define ACIS_RST_CUTOFF   8'h00
`define ACIS_AXES_ALL     3'h7
`endif

// ---- src/acis_pkg.sv ----
// Purpose: types of the interrupt status block
// Assumes: nothing
// Notes:   enum orders give the system mode read codes
`default_nettype none
package acis_pkg;
  typedef enum logic [1:0] {SYS_STANDBY, SYS_WAKE, SYS_SLEEP} acis_sysmode_type;
  typedef enum logic [3:0] {BUS_IDLE, BUS_ADDR, BUS_ADDR_ACK, BUS_REG, BUS_IN_ACK, BUS_WDATA,
                            BUS_RDATA, BUS_HOST_ACK} acis_bus_type;
  typedef struct packed {
    logic transient_active;
    logic orientation_changed_flag;
    logic tap_active;
    logic fall_motion_active;
    logic sample_set_ready_flag;
    logic sample_overwrite_flag;
  } acis_events_type;
  typedef struct packed {
    logic       highpass_output_select;
    logic [1:0] full_scale_select;
    logic       tap_highpass_bypass;
    logic       tap_lowpass_enable;
    logic [1:0] cutoff_select;
    logic       low_rate_select;
  } acis_config_type;
  typedef struct packed {
    logic [1:0] first;
    logic [1:0] second;
  } acis_sync_state_type;
  typedef struct packed {
    logic [7:0] flag;
    logic [7:0] prev;
  } acis_flag_state_type;
  typedef struct packed {
    acis_bus_type     phase;
    logic [3:0]       bitcnt;
    logic [7:0]       shift;
    logic [7:0]       pointer;
    logic             rw;
    logic             nack;
    logic             sda_oe;
    logic [7:0]       format;
    logic [7:0]       cutoff;
    acis_sysmode_type mode;
    logic             low_rate;
    logic             mode_event;
    logic [7:0]       idle_cnt;
    logic [2:0]       axes_read;
    logic             scl_d;
    logic             sda_d;
    logic             rd_strobe;
    logic [7:0]       rd_addr;
  } acis_core_type;
endpackage : acis_pkg
`default_nettype wire

// ---- src/acis_sync.sv ----
// Purpose: two-stage synchroniser for the bus pins
// Assumes: pins idle high
// Notes:   only the second stage leaves this module
`default_nettype none
module acis_sync (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  // pins
  input  wire logic [1:0] async_in,
  output logic      [1:0] sync_out
);
  import acis_pkg::*;
  acis_sync_state_type q;
  acis_sync_state_type next_q;

  always_comb
  begin
    next_q.first  = async_in;
    next_q.second = q.first;
  end

  // reset high so no false start appears at release
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      q <= '1;
    else
      q <= next_q;
  end

  assign sync_out = q.second;
endmodule : acis_sync
`default_nettype wire

// ---- src/acis_flags.sv ----
// Purpose: sticky interrupt source flags, set on a rising cause, cleared by a read
// Assumes: cause and clear come from logic on sys_clk
// Notes:   set wins over a clear in the same cycle
`include "acis_defs.svh"
`default_nettype none
module acis_flags (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  // causes and clears
  input  wire logic [7:0] cause,
  input  wire logic [7:0] clear,
  // flags
  output logic      [7:0] flags
);
  import acis_pkg::*;
  localparam logic [7:0] USED = `ACIS_INTSRC_USED;
  acis_flag_state_type q;
  acis_flag_state_type next_q;

  always_comb
  begin
    next_q.prev = cause;
    for (int i = 0; i < 8; i++)
      next_q.flag[i] = ((cause[i] & ~q.prev[i]) | (q.flag[i] & ~clear[i])) & USED[i];
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      q <= '0;
    else
      q <= next_q;
  end

  assign flags = q.flag;

  a_rise_sets: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (cause[0] && !q.prev[0]) |=> flags[0]) else $error("rising cause did not set flag");
  a_level_no_set: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (q.prev[5] && cause[5] && clear[5]) |=> !flags[5]) else $error("held cause set flag again");
endmodule : acis_flags
`default_nettype wire

// ---- src/acis_top.sv ----
// Purpose: interrupt source, identity and data format registers behind a two-wire slave
// Assumes: sys_clk 40 MHz, far faster than the bus clock; event inputs on sys_clk
// Notes:   registers outside this block are read through ext_addr / ext_rd_data
`include "acis_defs.svh"
`default_nettype none
module acis_top #(
  parameter logic [7:0] ID_CODE  = 8'h5c, // arbitrary value
  parameter logic [6:0] DEV_ADDR = 7'h3a  // arbitrary value
) (
  // clock and reset
  input  wire logic                       sys_clk,
  input  wire logic                       sys_rst,
  // bus pins
  input  wire logic                       scl_in,
  input  wire logic                       sda_in,
  output logic                            sda_out,
  output logic                            sda_oe,
  // embedded function events and enables
  input  wire acis_pkg::acis_events_type  events,
  input  wire logic [7:0]                 int_enable,
  // sleep and wake control
  input  wire logic                       device_active,
  input  wire logic                       auto_sleep_enable,
  input  wire logic                       idle_tick,
  input  wire logic [7:0]                 sleep_idle_limit,
  input  wire logic [7:0]                 wake_select,
  // other registers of the device
  output logic [7:0]                      ext_addr,
  output logic                            ext_rd_strobe,
  input  wire logic [7:0]                 ext_rd_data,
  // configuration and status
  output var acis_pkg::acis_config_type   config_out,
  output logic [7:0]                      interrupt_source,
  output var acis_pkg::acis_sysmode_type  system_mode
);
  import acis_pkg::*;

  acis_core_type q;
  acis_core_type next_q;
  logic [1:0]    pins_s;
  logic          scl_s;
  logic          sda_s;
  logic          scl_rise;
  logic          scl_fall;
  logic          bus_start;
  logic          bus_stop;
  logic [7:0]    cause;
  logic [7:0]    clear;
  logic [7:0]    rd_data;
  logic [2:0]    axis_bit;
  logic          activity;
  logic          wake_hit;

  // ----------------------------------------
  // pin synchroniser and bus conditions
  // ----------------------------------------
  acis_sync u_sync (
    .sys_clk  (sys_clk),
    .sys_rst  (sys_rst),
    .async_in ({scl_in, sda_in}),
    .sync_out (pins_s)
  );

  assign scl_s     = pins_s[1];
  assign sda_s     = pins_s[0];
  assign scl_rise  = scl_s & ~q.scl_d;
  assign scl_fall  = ~scl_s & q.scl_d;
  assign bus_start = scl_s & q.scl_d & q.sda_d & ~sda_s;
  assign bus_stop  = scl_s & q.scl_d & ~q.sda_d & sda_s;

  // ----------------------------------------
  // interrupt causes and read clears
  // ----------------------------------------
  always_comb
  begin
    cause                  = 8'h00;
    cause[`ACIS_BIT_SLEEP] = q.mode_event & int_enable[`ACIS_BIT_SLEEP];
    cause[`ACIS_BIT_TRANS] = events.transient_active & int_enable[`ACIS_BIT_TRANS];
    cause[`ACIS_BIT_ORIENT] = events.orientation_changed_flag & int_enable[`ACIS_BIT_ORIENT];
    cause[`ACIS_BIT_TAP]   = events.tap_active & int_enable[`ACIS_BIT_TAP];
    cause[`ACIS_BIT_FALLMO] = events.fall_motion_active & int_enable[`ACIS_BIT_FALLMO];
    cause[`ACIS_BIT_SAMPLE] = (events.sample_set_ready_flag | events.sample_overwrite_flag)
                              & int_enable[`ACIS_BIT_SAMPLE];
  end

  always_comb
  begin
    axis_bit = 3'h0;
    if (q.rd_addr == `ACIS_ADDR_X_MSB)
      axis_bit = 3'h1;
    else if (q.rd_addr == `ACIS_ADDR_Y_MSB)
      axis_bit = 3'h2;
    else if (q.rd_addr == `ACIS_ADDR_Z_MSB)
      axis_bit = 3'h4;
    clear = 8'h00;
    if (q.rd_strobe)
    begin
      clear[`ACIS_BIT_SLEEP]  = (q.rd_addr == `ACIS_ADDR_SYSMODE);
      clear[`ACIS_BIT_TRANS]  = (q.rd_addr == `ACIS_ADDR_TRANS);
      clear[`ACIS_BIT_ORIENT] = (q.rd_addr == `ACIS_ADDR_ORIENT);
      clear[`ACIS_BIT_TAP]    = (q.rd_addr == `ACIS_ADDR_TAP);
      clear[`ACIS_BIT_FALLMO] = (q.rd_addr == `ACIS_ADDR_FALLMO);
      // a status read alone never completes the set
      clear[`ACIS_BIT_SAMPLE] = (axis_bit != 3'h0) && ((q.axes_read | axis_bit) == `ACIS_AXES_ALL);
    end
  end

  acis_flags u_flags (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .cause   (cause),
    .clear   (clear),
    .flags   (interrupt_source)
  );

  assign activity = |(cause & ~8'h80);
  assign wake_hit = |(cause & wake_select);

  // ----------------------------------------
  // read data
  // ----------------------------------------
  always_comb
  begin
    case (q.pointer)
      `ACIS_ADDR_SYSMODE: rd_data = {6'h00, q.mode};
      `ACIS_ADDR_INTSRC:  rd_data = interrupt_source;
      `ACIS_ADDR_IDENT:   rd_data = ID_CODE;
      `ACIS_ADDR_FORMAT:  rd_data = q.format;
      `ACIS_ADDR_CUTOFF:  rd_data = q.cutoff;
      default:            rd_data = ext_rd_data;
    endcase
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    logic do_load;
    logic do_write;
    do_load           = 1'b0;
    do_write          = 1'b0;
    next_q            = q;
    next_q.scl_d      = scl_s;
    next_q.sda_d      = sda_s;
    next_q.rd_strobe  = 1'b0;
    next_q.mode_event = 1'b0;

    if (clear[`ACIS_BIT_SAMPLE])
      next_q.axes_read = 3'h0;
    else if (q.rd_strobe)
      next_q.axes_read = q.axes_read | axis_bit;

    case (q.mode)
      SYS_STANDBY:
      begin
        next_q.idle_cnt = 8'h00;
        if (device_active)
          next_q.mode = SYS_WAKE;
      end
      SYS_WAKE:
      begin
        if (!device_active)
          next_q.mode = SYS_STANDBY;
        else if (activity)
          next_q.idle_cnt = 8'h00;
        else if (auto_sleep_enable && idle_tick)
        begin
          if (q.idle_cnt == sleep_idle_limit)
          begin
            next_q.mode       = SYS_SLEEP;
            next_q.mode_event = 1'b1;
            next_q.idle_cnt   = 8'h00;
          end
          else
            next_q.idle_cnt = q.idle_cnt + 8'h01;
        end
      end
      SYS_SLEEP:
      begin
        if (!device_active)
          next_q.mode = SYS_STANDBY;
        else if (wake_hit)
        begin
          next_q.mode       = SYS_WAKE;
          next_q.mode_event = 1'b1;
        end
      end
      default:
        next_q.mode = SYS_STANDBY;
    endcase
    next_q.low_rate = (next_q.mode == SYS_SLEEP);

    if (bus_start)
    begin
      next_q.phase  = BUS_ADDR;
      next_q.bitcnt = 4'h0;
      next_q.sda_oe = 1'b0;
    end
    else if (bus_stop)
    begin
      next_q.phase  = BUS_IDLE;
      next_q.sda_oe = 1'b0;
    end
    else
    begin
      case (q.phase)
        BUS_ADDR, BUS_REG, BUS_WDATA:
        begin
          if (scl_rise)
          begin
            next_q.shift  = {q.shift[6:0], sda_s};
            next_q.bitcnt = q.bitcnt + 4'h1;
          end
          else if (scl_fall && q.bitcnt == 4'h8)
          begin
            next_q.sda_oe = 1'b1;
            next_q.phase  = BUS_IN_ACK;
            if (q.phase == BUS_ADDR)
            begin
              next_q.rw    = q.shift[0];
              next_q.phase = BUS_ADDR_ACK;
              if (q.shift[7:1] != DEV_ADDR)
              begin
                next_q.sda_oe = 1'b0;
                next_q.phase  = BUS_IDLE;
              end
            end
            else if (q.phase == BUS_REG)
              next_q.pointer = q.shift;
            else
            begin
              do_write       = 1'b1;
              next_q.pointer = q.pointer + 8'h01;
            end
          end
        end
        BUS_ADDR_ACK, BUS_IN_ACK:
        begin
          if (scl_fall)
          begin
            next_q.sda_oe = 1'b0;
            next_q.bitcnt = 4'h0;
            next_q.phase  = (q.phase == BUS_IN_ACK) ? BUS_WDATA : BUS_REG;
            do_load       = (q.phase == BUS_ADDR_ACK) && q.rw;
          end
        end
        BUS_RDATA:
        begin
          if (scl_rise)
            next_q.bitcnt = q.bitcnt + 4'h1;
          else if (scl_fall && q.bitcnt == 4'h8)
          begin
            next_q.sda_oe = 1'b0;
            next_q.phase  = BUS_HOST_ACK;
          end
          else if (scl_fall)
          begin
            next_q.shift  = {q.shift[6:0], 1'b0};
            next_q.sda_oe = ~q.shift[6];
          end
        end
        BUS_HOST_ACK:
        begin
          if (scl_rise)
            next_q.nack = sda_s;
          else if (scl_fall && q.nack)
            next_q.phase = BUS_IDLE;
          else if (scl_fall)
            do_load = 1'b1;
        end
        default:
          next_q.phase = BUS_IDLE;
      endcase
    end

    // the read byte is captured here, so read side effects fire here too
    if (do_load)
    begin
      next_q.shift     = rd_data;
      next_q.sda_oe    = ~rd_data[7];
      next_q.rd_strobe = 1'b1;
      next_q.rd_addr   = q.pointer;
      next_q.pointer   = q.pointer + 8'h01;
      next_q.bitcnt    = 4'h0;
      next_q.phase     = BUS_RDATA;
    end

    // writes outside standby are dropped to keep the datapath consistent
    if (do_write && q.mode == SYS_STANDBY)
    begin
      case (q.pointer)
        `ACIS_ADDR_FORMAT: next_q.format = q.shift & `ACIS_MASK_FORMAT;
        `ACIS_ADDR_CUTOFF: next_q.cutoff = q.shift & `ACIS_MASK_CUTOFF;
        default:           next_q.format = q.format;
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      q        <= '0;
      q.scl_d  <= 1'b1;
      q.sda_d  <= 1'b1;
      q.format <= `ACIS_RST_FORMAT;
      q.cutoff <= `ACIS_RST_CUTOFF;
    end
    else
      q <= next_q;
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign sda_out       = 1'b0;
  assign sda_oe        = q.sda_oe;
  assign ext_addr      = q.pointer;
  assign ext_rd_strobe = q.rd_strobe;
  assign system_mode   = q.mode;
  assign config_out.highpass_output_select = q.format[4];
  assign config_out.full_scale_select      = q.format[1:0];
  assign config_out.tap_highpass_bypass    = q.cutoff[5];
  assign config_out.tap_lowpass_enable     = q.cutoff[4];
  assign config_out.cutoff_select          = q.cutoff[1:0];
  assign config_out.low_rate_select        = q.low_rate;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  sequence s_last_axis;
    q.rd_strobe && q.rd_addr == `ACIS_ADDR_Z_MSB && q.axes_read == 3'h3 && !$rose(cause[`ACIS_BIT_SAMPLE]);
  endsequence

  a_reset_clean: assert property ($past(sys_rst) |-> interrupt_source == 8'h00)
    else $error("flags not zero after reset");
  a_ident_fixed: assert property (q.rd_strobe && q.rd_addr == `ACIS_ADDR_IDENT |-> q.shift == ID_CODE)
    else $error("identity read wrong");
  a_sleep_flag: assert property ($rose(q.low_rate) && int_enable[7] |=> interrupt_source[7])
    else $error("sleep entry did not set flag");
  a_wake_flag: assert property ($fell(q.low_rate) && q.mode == SYS_WAKE && int_enable[7]
    |=> interrupt_source[7]) else $error("wake did not set flag");
  a_mode_clear: assert property (clear[7] && !q.mode_event |=> !interrupt_source[7])
    else $error("system mode read did not clear flag");
  a_tap_clear: assert property (q.rd_strobe && q.rd_addr == `ACIS_ADDR_TAP && !$rose(cause[3])
    |=> !interrupt_source[3]) else $error("tap read did not clear flag");
  a_status_keeps: assert property (q.rd_strobe && q.rd_addr == `ACIS_ADDR_STATUS && interrupt_source[0]
    |=> interrupt_source[0]) else $error("status read cleared sample flag");
  a_axes_clear: assert property (s_last_axis |=> !interrupt_source[0])
    else $error("axis reads did not clear sample flag");
  a_trans_set: assert property ($rose(events.transient_active) && int_enable[5] |=> interrupt_source[5])
    else $error("transient event not flagged");
  a_ro_ignored: assert property (q.mode == SYS_STANDBY && q.phase == BUS_WDATA
    && q.pointer == `ACIS_ADDR_IDENT |=> $stable(q.format) && $stable(q.cutoff))
    else $error("write to read-only changed state");
endmodule : acis_top
`default_nettype wire

// ---- verification/acis_host.sv ----
// Purpose: two-wire host model that reads and writes the block's registers
// Assumes: scl period of 20 sys_clk, above the 16 the slave needs
// Notes:   open drain; released sda floats high through the bench pull-up
`default_nettype none
module acis_host #(
  parameter logic [6:0] DEV_ADDR = 7'h3a
) (
  // clock
  input  wire logic sys_clk,
  // bus
  input  wire logic sda,
  output logic      scl,
  output logic      sda_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    scl = 1'b1;
    sda_oe = 1'b0;
  end
  // ----------------------------------------
  // bit and byte cycles
  // ----------------------------------------
  task automatic q();
    repeat (5) @(posedge sys_clk);
  endtask : q
  // sda only moves while scl is low, except in start and stop
  task automatic bit_io(input logic b, output logic r);
    sda_oe <= ~b;
    q();
    scl <= 1'b1;
    q();
    r = sda;
    q();
    scl <= 1'b0;
    q();
  endtask : bit_io
  task automatic start();
    sda_oe <= 1'b0;
    q();
    scl <= 1'b1;
    q();
    sda_oe <= 1'b1;
    q();
    scl <= 1'b0;
    q();
  endtask : start
  task automatic stop();
    sda_oe <= 1'b1;
    q();
    scl <= 1'b1;
    q();
    sda_oe <= 1'b0;
    q();
  endtask : stop
  // ninth bit always released: ack from slave, nack from host on reads
  task automatic xfer(input logic [7:0] d, output logic [7:0] r);
    logic a;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], r[i]);
    bit_io(1'b1, a);
  endtask : xfer
  // ----------------------------------------
  // register accesses
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    start();
    xfer({DEV_ADDR, 1'b0}, r);
    xfer(a, r);
    xfer(d, r);
    stop();
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    logic [7:0] r;
    start();
    xfer({DEV_ADDR, 1'b0}, r);
    xfer(a, r);
    start();
    xfer({DEV_ADDR, 1'b1}, r);
    xfer(8'hff, d);
    stop();
  endtask : rd
endmodule : acis_host
`default_nettype wire

// ---- verification/testbench.sv ----
// Purpose: self-checking bench of the interrupt source and format registers
// Assumes: host model on the bus, other registers return their address XOR xr
// Notes:   flag model mf is kept by hand beside each stimulus
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import acis_pkg::*;
  localparam logic [7:0] ID  = 8'ha7; // arbitrary value
  localparam logic [6:0] DEV = 7'h2c; // arbitrary value
  logic sys_clk, sys_rst, scl, h_oe, sda_out, sda_oe, device_active;
  logic auto_sleep_enable, idle_tick, ext_rd_strobe;
  wire logic sda;
  acis_events_type events;
  acis_config_type config_out;
  acis_sysmode_type system_mode;
  logic [7:0] int_enable, sleep_idle_limit, wake_select, ext_addr, ext_rd_data;
  logic [7:0] interrupt_source, xr, d, w, ef;
  logic [7:0] ca [6] = '{8'h00, 8'h00, 8'h16, 8'h22, 8'h10, 8'h1e};
  integer seed = 36024, miscompares = 0, checked = 0, mf = 0, i, strobes = 0;
  // pull-up on the shared data line; the slave pulls only with a low data value
  assign sda = ~(h_oe | (sda_oe & ~sda_out));
  assign ext_rd_data = ext_addr ^ xr;
  acis_top #(.ID_CODE(ID), .DEV_ADDR(DEV)) uut (.sys_clk, .sys_rst, .scl_in(scl), .sda_in(sda), .sda_out,
    .sda_oe, .events, .int_enable, .device_active, .auto_sleep_enable, .idle_tick, .sleep_idle_limit,
    .wake_select, .ext_addr, .ext_rd_strobe, .ext_rd_data, .config_out, .interrupt_source, .system_mode);
  acis_host #(.DEV_ADDR(DEV)) host (.sys_clk, .sda, .scl, .sda_oe(h_oe));
  // one read strobe per byte read, none for writes
  always @(posedge sys_clk)
    if (ext_rd_strobe)
      strobes <= strobes + 1;
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    checked++;
    if (s !== e)
    begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : complete_run
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : cyc
  task automatic set(input logic [5:0] v, input logic [7:0] en);
    @(posedge sys_clk);
    events <= acis_events_type'(v);
    int_enable <= en;
    cyc(3);
  endtask : set
  task automatic tick();
    @(posedge sys_clk);
    idle_tick <= 1'b1;
    @(posedge sys_clk);
    idle_tick <= 1'b0;
    cyc(2);
  endtask : tick
  function automatic logic [7:0] fmt();
    return {3'h0, config_out.highpass_output_select, 2'h0, config_out.full_scale_select};
  endfunction : fmt
  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  initial
  begin
    repeat (100000) @(posedge sys_clk);
    miscompares++;
    complete_run();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    {sys_rst, device_active, auto_sleep_enable, idle_tick} = 4'h8;
    {int_enable, sleep_idle_limit, wake_select, xr} = 32'h0;
    events = '0;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    cyc(4);
    chk(interrupt_source, 8'h00);
    chk(config_out, 8'h00);
    host.rd(8'h0d, d);
    chk(d, ID);
    host.wr(8'h0d, 8'hff);
    host.wr(8'h0c, 8'hff);
    host.rd(8'h0d, d);
    chk(d, ID);
    chk(strobes[7:0], 8'h02);
    chk(interrupt_source, 8'h00);
    // all four full-scale codes, reserved one included
    for (i = 0; i < 4; i++)
    begin
      w = 8'($random(seed));
      w[1:0] = i[1:0];
      host.wr(8'h0e, w);
      host.wr(8'h0f, w);
      ef = w & 8'h13;
      chk(fmt(), ef);
      chk({2'h0, config_out.tap_highpass_bypass, config_out.tap_lowpass_enable, 2'h0,
           config_out.cutoff_select}, w & 8'h33);
      host.rd(8'h0e, d);
      chk(d, ef);
      host.rd(8'h0f, d);
      chk(d, w & 8'h33);
    end
    // event held high across the clearing read must not set again
    for (i = 2; i < 6; i++)
    begin
      set(6'h01 << i, 8'h00);
      chk(interrupt_source, mf[7:0]);
      set(6'h00, 8'h01 << i);
      set(6'h01 << i, 8'h01 << i);
      mf = mf | (1 << i);
      chk(interrupt_source, mf[7:0]);
      @(posedge sys_clk);
      xr <= 8'($random(seed));
      host.rd(ca[i], d);
      chk(d, ca[i] ^ xr);
      mf = mf & ~(1 << i);
      cyc(3);
      chk(interrupt_source, mf[7:0]);
      set(6'h00, 8'h01 << i);
    end
    for (i = 0; i < 2; i++)
    begin
      set(6'h01 << i, 8'h01);
      mf = 1;
      chk(interrupt_source, mf[7:0]);
      host.rd(8'h00, d);
      host.rd((i == 0) ? 8'h03 : 8'h01, d);
      host.rd((i == 0) ? 8'h01 : 8'h03, d);
      chk(interrupt_source, mf[7:0]);
      host.rd(8'h05, d);
      mf = 0;
      cyc(3);
      chk(interrupt_source, mf[7:0]);
      set(6'h00, 8'h01);
    end
    @(posedge sys_clk);
    {device_active, auto_sleep_enable} <= 2'h3;
    sleep_idle_limit <= 8'h02;
    wake_select <= 8'h08;
    int_enable <= 8'h88;
    cyc(3);
    chk({6'h0, system_mode}, 8'h01);
    host.wr(8'h0e, ~ef);
    chk(fmt(), ef);
    tick();
    tick();
    chk({6'h0, system_mode}, 8'h01);
    tick();
    mf = 8'h80;
    chk({6'h0, system_mode}, 8'h02);
    chk({7'h0, config_out.low_rate_select}, 8'h01);
    chk(interrupt_source, mf[7:0]);
    host.rd(8'h0b, d);
    chk(d, 8'h02);
    mf = 0;
    chk(interrupt_source, mf[7:0]);
    set(6'h08, 8'h88);
    mf = 8'h88;
    chk({6'h0, system_mode}, 8'h01);
    chk({7'h0, config_out.low_rate_select}, 8'h00);
    chk(interrupt_source, mf[7:0]);
    host.rd(8'h0b, d);
    chk(d, 8'h01);
    host.rd(8'h22, d);
    mf = 0;
    chk(interrupt_source, mf[7:0]);
    complete_run();
  end
endmodule : testbench
`default_nettype wire
